// file: rtl/mcu_interrupt_controller.sv
// Purpose: Collects, prioritises and sequences interrupts for the 8-bit core.
// Assumes: Stack memory shows the top byte on pop_data in each cycle that pop_req is high.
// Notes:   The core applies mask_set and mask_clear one cycle after the pulse.
`timescale 1ns/1ns
`default_nettype none
module mcu_interrupt_controller #(
  parameter int unsigned STAB_CYCLES = irq_pkg::HALT_STAB_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  ext_irq_pin,
  input  wire logic        flash_req,
  input  wire logic        end_suspend,
  input  wire logic [3:0]  periph_flag,
  input  wire logic [3:0]  periph_enable,
  input  wire logic [3:0]  periph_clear,
  input  wire logic        instr_done,
  input  wire logic        trap_exec,
  input  wire logic        return_from_irq,
  input  wire logic        wait_exec,
  input  wire logic        halt_exec,
  input  wire logic        mask_bit,
  input  wire logic [15:0] pc_now,
  input  wire logic [7:0]  x_now,
  input  wire logic [7:0]  a_now,
  input  wire logic [7:0]  condition_code_reg,
  input  wire logic [7:0]  pop_data,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             push_valid,
  output logic [7:0]       push_data,
  output logic             pop_req,
  output logic             pc_load,
  output logic [15:0]      pc_value,
  output logic             mask_set,
  output logic             mask_clear,
  output logic             restore_valid,
  output logic [15:0]      restore_pc,
  output logic [7:0]       restore_x,
  output logic [7:0]       restore_a,
  output logic [7:0]       restore_cc,
  output logic             cpu_hold,
  output logic             osc_enable
);

  irq_pkg::state_type state;
  irq_pkg::src_type   sel;
  irq_pkg::src_type   winner;
  logic [7:0]         ext_irq_enable_reg;
  logic               reset_pend, trap_pend, flash_pend, susp_pend;
  logic [3:0]         periph_pend, periph_prev, periph_req;
  logic [2:0]         step;
  logic [12:0]        stab_cnt;
  logic [15:0]        ctx_pc;
  logic [7:0]         ctx_x, ctx_a, ctx_cc;
  logic               ext_any, vector_cycle;
  ext_pin_if          pins ();

  ext_pin_catcher #(.WIDTH(8), .RISING(irq_pkg::EXT_RISING)) u_catcher (
    .clock       (clock),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .ext_irq_pin (ext_irq_pin),
    .bus         (pins.catcher)
  );

  assign vector_cycle = (state == irq_pkg::ST_VECTOR);
  assign pins.enable  = ext_irq_enable_reg;
  assign pins.service = vector_cycle && (sel == irq_pkg::SRC_EXT);
  assign ext_any      = |pins.pend;
  assign periph_req   = periph_pend & periph_enable;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_enable_reg <= irq_pkg::EXT_ENABLE_RESET;
      reg_rdata          <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == irq_pkg::EXT_ENABLE_ADDR) begin
        ext_irq_enable_reg <= reg_wdata;
      end
      reg_rdata <= (reg_addr == irq_pkg::EXT_ENABLE_ADDR) ? ext_irq_enable_reg : 8'h00;
    end
  end

  // Core-side events latch until serviced; a new event beats a same-cycle clear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reset_pend <= 1'b1;
      trap_pend  <= 1'b0;
      flash_pend <= 1'b0;
      susp_pend  <= 1'b0;
    end else if (clk_en) begin
      if (vector_cycle && sel == irq_pkg::SRC_RESET) begin
        reset_pend <= 1'b0;
      end
      if (trap_exec) begin
        trap_pend <= 1'b1;
      end else if (vector_cycle && sel == irq_pkg::SRC_TRAP) begin
        trap_pend <= 1'b0;
      end
      if (flash_req) begin
        flash_pend <= 1'b1;
      end else if (vector_cycle && sel == irq_pkg::SRC_FLASH) begin
        flash_pend <= 1'b0;
      end
      if (end_suspend) begin
        susp_pend <= 1'b1;
      end else if (vector_cycle && sel == irq_pkg::SRC_SUSPEND) begin
        susp_pend <= 1'b0;
      end
    end
  end

  // Peripheral latches ignore servicing; only the clearing sequence drops them.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periph_prev <= 4'h0;
      periph_pend <= 4'h0;
    end else if (clk_en) begin
      periph_prev <= periph_flag;
      periph_pend <= (periph_flag & ~periph_prev) | (periph_pend & ~periph_clear);
    end
  end

  always_comb begin
    winner = irq_pkg::SRC_NONE;
    if (reset_pend) begin
      winner = irq_pkg::SRC_RESET;
    end else if (trap_pend) begin
      winner = irq_pkg::SRC_TRAP;
    end else if (!mask_bit) begin
      if (flash_pend) begin
        winner = irq_pkg::SRC_FLASH;
      end else if (susp_pend) begin
        winner = irq_pkg::SRC_SUSPEND;
      end else if (ext_any) begin
        winner = irq_pkg::SRC_EXT;
      end else if (periph_req[0]) begin
        winner = irq_pkg::SRC_TIMER;
      end else if (periph_req[1]) begin
        winner = irq_pkg::SRC_TWI;
      end else if (periph_req[2]) begin
        winner = irq_pkg::SRC_SERIAL;
      end else if (periph_req[3]) begin
        winner = irq_pkg::SRC_USBP;
      end
    end
  end

  // Context capture and source latch happen in the cycle an entry is accepted.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state         <= irq_pkg::ST_IDLE;
      sel           <= irq_pkg::SRC_NONE;
      step          <= 3'h0;
      stab_cnt      <= 13'h0000;
      ctx_pc        <= 16'h0000;
      ctx_x         <= 8'h00;
      ctx_a         <= 8'h00;
      ctx_cc        <= 8'h00;
      push_valid    <= 1'b0;
      push_data     <= 8'h00;
      pop_req       <= 1'b0;
      pc_load       <= 1'b0;
      pc_value      <= 16'h0000;
      mask_set      <= 1'b0;
      mask_clear    <= 1'b0;
      restore_valid <= 1'b0;
      restore_pc    <= 16'h0000;
      restore_x     <= 8'h00;
      restore_a     <= 8'h00;
      restore_cc    <= 8'h00;
      cpu_hold      <= 1'b1;
      osc_enable    <= 1'b1;
    end else if (clk_en) begin
      push_valid    <= 1'b0;
      pop_req       <= 1'b0;
      pc_load       <= 1'b0;
      mask_set      <= 1'b0;
      mask_clear    <= 1'b0;
      restore_valid <= 1'b0;
      case (state)
        irq_pkg::ST_IDLE: begin
          cpu_hold <= 1'b0;
          if (winner == irq_pkg::SRC_RESET) begin
            sel      <= winner;
            state    <= irq_pkg::ST_VECTOR;
            cpu_hold <= 1'b1;
          end else if (return_from_irq) begin
            state    <= irq_pkg::ST_POP;
            step     <= 3'h0;
            cpu_hold <= 1'b1;
          end else if (instr_done && winner != irq_pkg::SRC_NONE) begin
            sel      <= winner;
            ctx_pc   <= pc_now;
            ctx_x    <= x_now;
            ctx_a    <= a_now;
            ctx_cc   <= condition_code_reg;
            step     <= 3'h0;
            state    <= irq_pkg::ST_PUSH;
            cpu_hold <= 1'b1;
          end else if (wait_exec) begin
            mask_clear <= 1'b1;
            state      <= irq_pkg::ST_WAIT;
            cpu_hold   <= 1'b1;
          end else if (halt_exec) begin
            mask_clear <= 1'b1;
            osc_enable <= 1'b0;
            state      <= irq_pkg::ST_HALT;
            cpu_hold   <= 1'b1;
          end
        end
        irq_pkg::ST_WAIT: begin
          if (winner != irq_pkg::SRC_NONE) begin
            sel    <= winner;
            ctx_pc <= pc_now;
            ctx_x  <= x_now;
            ctx_a  <= a_now;
            ctx_cc <= condition_code_reg;
            step   <= 3'h0;
            state  <= irq_pkg::ST_PUSH;
          end
        end
        irq_pkg::ST_HALT: begin
          if (ext_any || susp_pend) begin
            osc_enable <= 1'b1;
            stab_cnt   <= 13'h0000;
            state      <= irq_pkg::ST_STAB;
          end
        end
        irq_pkg::ST_STAB: begin
          stab_cnt <= stab_cnt + 13'h0001;
          if (stab_cnt == 13'(STAB_CYCLES - 1)) begin
            sel    <= winner;
            ctx_pc <= pc_now;
            ctx_x  <= x_now;
            ctx_a  <= a_now;
            ctx_cc <= condition_code_reg;
            step   <= 3'h0;
            state  <= (winner == irq_pkg::SRC_NONE) ? irq_pkg::ST_IDLE : irq_pkg::ST_PUSH;
          end
        end
        irq_pkg::ST_PUSH: begin
          // Y is deliberately absent from the saved frame.
          push_valid <= 1'b1;
          case (step)
            3'h0:    push_data <= ctx_pc[7:0];
            3'h1:    push_data <= ctx_pc[15:8];
            3'h2:    push_data <= ctx_x;
            3'h3:    push_data <= ctx_a;
            default: push_data <= ctx_cc;
          endcase
          step <= step + 3'h1;
          if (step == irq_pkg::STACK_BYTES - 3'h1) begin
            state <= irq_pkg::ST_VECTOR;
          end
        end
        irq_pkg::ST_VECTOR: begin
          pc_load  <= 1'b1;
          pc_value <= irq_pkg::vector_of(sel);
          mask_set <= 1'b1;
          state    <= irq_pkg::ST_IDLE;
        end
        irq_pkg::ST_POP: begin
          // Pop order is CC, A, X, PCH, PCL; data trails each request by one cycle.
          pop_req <= (step < irq_pkg::STACK_BYTES);
          case (step)
            3'h1:    restore_cc <= pop_data;
            3'h2:    restore_a <= pop_data;
            3'h3:    restore_x <= pop_data;
            3'h4:    restore_pc[15:8] <= pop_data;
            3'h5:    restore_pc[7:0] <= pop_data;
            default: restore_pc <= restore_pc;
          endcase
          step <= step + 3'h1;
          if (step == irq_pkg::STACK_BYTES) begin
            restore_valid <= 1'b1;
            state         <= irq_pkg::ST_IDLE;
          end
        end
        default: state <= irq_pkg::ST_IDLE;
      endcase
    end
  end

  sequence push_frame;
    push_valid [*5] ##1 (!push_valid && pc_load);
  endsequence

  sequence pop_frame;
    pop_req [*5] ##1 restore_valid;
  endsequence

  mask_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state == irq_pkg::ST_IDLE && mask_bit && !reset_pend && !trap_pend)
      |=> state != irq_pkg::ST_PUSH)
    else $error("Masked request entered service.");

  boundary_entry_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state == irq_pkg::ST_IDLE ##1 state == irq_pkg::ST_PUSH) |-> $past(instr_done))
    else $error("Entry began mid-instruction.");

  push_frame_a: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    $rose(push_valid) |-> push_frame)
    else $error("Context push was not five bytes then vector.");

  mask_entry_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pc_load) |-> mask_set)
    else $error("Mask not set on entry.");

  vector_pick_a: assert property (@(posedge clock) disable iff (!rst_n)
    pc_load |-> pc_value == irq_pkg::vector_of(sel))
    else $error("Wrong vector loaded.");

  pop_frame_a: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    $rose(pop_req) |-> pop_frame)
    else $error("Return did not pop five bytes.");

  trap_unmasked_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state == irq_pkg::ST_IDLE && trap_pend && !reset_pend && instr_done
      && !return_from_irq) |=> state == irq_pkg::ST_PUSH)
    else $error("Trap not taken.");

  halt_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state == irq_pkg::ST_HALT && !ext_any && !susp_pend) |=> state == irq_pkg::ST_HALT)
    else $error("Halt left without a wake source.");

endmodule
`default_nettype wire

// file: rtl/irq_pkg.sv
// Purpose: Shared constants, types and lookups for the interrupt controller.
// Assumes: One CPU clock; the CPU core owns the mask bit and the stack memory.
// Notes:   Rule summary follows.
// What this block does
// - Masked requests wait pending until mask clears.
// - Entry starts only at an instruction boundary.
// - Entry pushes PC, X, A and CC.
// - Entry sets the global mask bit.
// - PC loads the selected vector after saving.
// - Return pops saved context and resumes.
// - Fixed priority order among pending sources.
// - Trap enters regardless of mask bit.
// - Any request wakes from wait.
// - Only pins, end-suspend or reset leave halt.
// - Inputs 1,2,5,6 rising; 3,4,7,8 falling.
// - Pin request needs its enable bit.
// - Peripheral flag needs enable and clear mask.
// - Clearing sequence discards the pending latch.
// - Fixed vector address per source.
// - Pin enable register at 0008h, resets zero.
// - Enabled pins OR into one request.
// - Second index register never stacked.
package irq_pkg;

  localparam logic [15:0] EXT_ENABLE_ADDR  = 16'h0008;
  localparam logic [7:0]  EXT_ENABLE_RESET = 8'h00;
  localparam logic [7:0]  EXT_RISING       = 8'h33;
  localparam logic [2:0]  STACK_BYTES      = 3'h5;
  localparam int unsigned HALT_STAB_CYCLES = 4096;

  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] VEC_TRAP    = 16'hfffc;
  localparam logic [15:0] VEC_FLASH   = 16'hfffa;
  localparam logic [15:0] VEC_SUSPEND = 16'hfff8;
  localparam logic [15:0] VEC_EXT     = 16'hfff6;
  localparam logic [15:0] VEC_TIMER   = 16'hfff4;
  localparam logic [15:0] VEC_TWI     = 16'hfff2;
  localparam logic [15:0] VEC_SERIAL  = 16'hfff0;
  localparam logic [15:0] VEC_USBP    = 16'hffee;

  typedef enum logic [3:0] {
    SRC_RESET   = 4'h0,
    SRC_TRAP    = 4'h1,
    SRC_FLASH   = 4'h2,
    SRC_SUSPEND = 4'h3,
    SRC_EXT     = 4'h4,
    SRC_TIMER   = 4'h5,
    SRC_TWI     = 4'h6,
    SRC_SERIAL  = 4'h7,
    SRC_USBP    = 4'h8,
    SRC_NONE    = 4'hf
  } src_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PUSH   = 3'b001,
    ST_VECTOR = 3'b010,
    ST_POP    = 3'b011,
    ST_WAIT   = 3'b100,
    ST_HALT   = 3'b101,
    ST_STAB   = 3'b110
  } state_type;

  function automatic logic [15:0] vector_of(input src_type s);
    case (s)
      SRC_TRAP:    vector_of = VEC_TRAP;
      SRC_FLASH:   vector_of = VEC_FLASH;
      SRC_SUSPEND: vector_of = VEC_SUSPEND;
      SRC_EXT:     vector_of = VEC_EXT;
      SRC_TIMER:   vector_of = VEC_TIMER;
      SRC_TWI:     vector_of = VEC_TWI;
      SRC_SERIAL:  vector_of = VEC_SERIAL;
      SRC_USBP:    vector_of = VEC_USBP;
      default:     vector_of = VEC_RESET;
    endcase
  endfunction

endpackage

// file: rtl/ext_pin_if.sv
// Purpose: Carries pin enables, pending bits and the service pulse.
// Assumes: Both ends on the CPU clock.
// Notes:   Pending bits are held in the pin catcher.
`timescale 1ns/1ns
`default_nettype none
interface ext_pin_if;
  logic [7:0] enable;
  logic [7:0] pend;
  logic       service;
  modport catcher (input enable, input service, output pend);
  modport ctrl    (output enable, output service, input pend);
endinterface
`default_nettype wire

// file: rtl/ext_pin_catcher.sv
// Purpose: Synchronises the external interrupt pins and latches their edges.
// Assumes: Pins are asynchronous to the CPU clock.
// Notes:   A level counts once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module ext_pin_catcher #(
  parameter int         WIDTH  = 8,
  parameter logic [7:0] RISING = irq_pkg::EXT_RISING
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] ext_irq_pin,
  ext_pin_if.catcher            bus
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic s1, s2, s3, stable, stable_d, edge_seen;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else if (clk_en) begin
          s1 <= ext_irq_pin[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // The filtered level starts low so a pin idling high gives no edge until it settles.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stable   <= 1'b0;
          stable_d <= 1'b0;
        end else if (clk_en) begin
          if (s2 == s3) begin
            stable <= s3;
          end
          stable_d <= stable;
        end
      end
      assign edge_seen = RISING[i] ? (stable & ~stable_d) : (~stable & stable_d);
      // A new edge in the service cycle survives the clear.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          bus.pend[i] <= 1'b0;
        end else if (clk_en) begin
          if (edge_seen && bus.enable[i]) begin
            bus.pend[i] <= 1'b1;
          end else if (bus.service) begin
            bus.pend[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: test/core_model.sv
// Purpose: Core-side partner holding the global mask bit and the stack memory.
// Assumes: Controller pulses last one clock; the top byte stands while a pop request is high.
// Notes:   Idle pop data shows the inverse of the last byte popped.
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       push_valid,
  input  wire logic [7:0] push_data,
  input  wire logic       pop_req,
  input  wire logic       mask_set,
  input  wire logic       mask_clear,
  input  wire logic       restore_valid,
  input  wire logic [7:0] restore_cc,
  input  wire logic       sw_set,
  input  wire logic       sw_clr,
  output logic            mask_bit,
  output logic [7:0]      pop_data
);
  logic [7:0] stack [0:127];
  logic [7:0] last = 8'h00;
  int         depth = 0;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_bit <= 1'b1;
    end else if (mask_set || sw_set) begin
      mask_bit <= 1'b1;
    end else if (mask_clear || sw_clr) begin
      mask_bit <= 1'b0;
    end else if (restore_valid) begin
      mask_bit <= restore_cc[3];
    end
  end
  // A stale byte would hide a missing pop, so idle cycles show its inverse.
  // The controller takes each byte at the edge that ends its pop request cycle.
  assign pop_data = (pop_req && depth > 0) ? stack[depth - 1] : ~last;
  always @(posedge clock) begin
    if (push_valid) begin
      stack[depth] <= push_data;
      depth <= depth + 1;
    end else if (pop_req && depth > 0) begin
      last <= stack[depth - 1];
      depth <= depth - 1;
    end
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Halt stabilisation shortened to 8 cycles.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [6:0] DONE = 7'h40, RET = 7'h20, TRAP = 7'h10, WAITC = 7'h08;
  localparam logic [6:0] HALTC = 7'h04, FLASH = 7'h02, SUSP = 7'h01;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  ext_irq_pin = 8'hcc;
  logic [6:0]  pulses = 7'h00;
  logic        instr_done, return_from_irq, trap_exec, wait_exec, halt_exec;
  logic        flash_req, end_suspend, mask_bit, sw_set = 1'b0, sw_clr = 1'b0;
  logic [3:0]  periph_flag = 4'h0, periph_enable = 4'h0, periph_clear = 4'h0;
  logic [15:0] pc_now = 16'h0000, reg_addr = 16'h0008, pc_value, restore_pc;
  logic [7:0]  x_now = 8'h00, a_now = 8'h00, condition_code_reg = 8'h00;
  logic [7:0]  reg_wdata = 8'h00, pop_data, reg_rdata, push_data;
  logic [7:0]  restore_x, restore_a, restore_cc, v;
  logic        reg_wr = 1'b0, push_valid, pop_req, pc_load, mask_set, mask_clear;
  logic        restore_valid, cpu_hold, osc_enable;
  logic [15:0] order [4] = '{16'hfffa, 16'hfff8, 16'hfff4, 16'hfff0};
  int          num_errors = 0;
  int          n_checks = 0;
  assign {instr_done, return_from_irq, trap_exec, wait_exec} = pulses[6:3];
  assign {halt_exec, flash_req, end_suspend} = pulses[2:0];
  always #10 clock = ~clock;
  mcu_interrupt_controller #(.STAB_CYCLES(8)) dut (
    .clock, .rst_n, .clk_en, .ext_irq_pin, .flash_req, .end_suspend, .periph_flag,
    .periph_enable, .periph_clear, .instr_done, .trap_exec, .return_from_irq,
    .wait_exec, .halt_exec, .mask_bit, .pc_now, .x_now, .a_now, .condition_code_reg,
    .pop_data, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .push_valid, .push_data,
    .pop_req, .pc_load, .pc_value, .mask_set, .mask_clear, .restore_valid,
    .restore_pc, .restore_x, .restore_a, .restore_cc, .cpu_hold, .osc_enable);
  core_model core (
    .clock, .rst_n, .push_valid, .push_data, .pop_req, .mask_set, .mask_clear,
    .restore_valid, .restore_cc, .sw_set, .sw_clr, .mask_bit, .pop_data);
  // Inputs 3, 4, 7 and 8 react to falling edges, so they rest high.
  function automatic logic idle_of(input int i);
    return (i % 4) > 1;
  endfunction
  function automatic logic [15:0] vec_of_periph(input int p);
    return 16'hfff4 - 16'(2 * p);
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic kick(input logic [6:0] k);
    @(posedge clock);
    pulses <= k;
    @(posedge clock);
    pulses <= 7'h00;
  endtask
  task automatic setmask(input logic m);
    @(posedge clock);
    {sw_set, sw_clr} <= m ? 2'b10 : 2'b01;
    @(posedge clock);
    {sw_set, sw_clr} <= 2'b00;
    @(posedge clock);
  endtask
  task automatic clr(input logic [3:0] m);
    @(posedge clock);
    periph_flag <= periph_flag & ~m;
    periph_clear <= m;
    @(posedge clock);
    periph_clear <= 4'h0;
  endtask
  task automatic pin(input int i, input logic act);
    @(posedge clock);
    ext_irq_pin[i] <= act ? ~idle_of(i) : idle_of(i);
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(negedge clock);
  endtask
  task automatic set_ctx;
    @(posedge clock);
    pc_now <= 16'($urandom);
    x_now <= 8'($urandom);
    a_now <= 8'($urandom);
    condition_code_reg <= {4'($urandom), mask_bit, 3'($urandom)};
    @(negedge clock);
  endtask
  task automatic wait_load;
    int t;
    t = 0;
    while (pc_load !== 1'b1 && t < 10) begin
      @(negedge clock);
      t++;
    end
  endtask
  task automatic serve(input logic [15:0] vec, input logic [6:0] k);
    logic [7:0] b [5];
    int n;
    int t;
    b = '{pc_now[7:0], pc_now[15:8], x_now, a_now, condition_code_reg};
    n = 0;
    t = 0;
    if (k != 7'h00) kick(k);
    while (n < 5 && t < 60) begin
      @(negedge clock);
      t++;
      if (push_valid === 1'b1) begin
        chk("push byte", 16'(b[n]), 16'(push_data));
        chk("hold in push", 16'd1, 16'(cpu_hold));
        n++;
      end
    end
    chk("push count", 16'd5, 16'(n));
    wait_load;
    chk("vector", vec, pc_value);
    chk("mask set", 16'd1, 16'(mask_set));
    kick(RET);
    t = 0;
    while (restore_valid !== 1'b1 && t < 12) begin
      @(negedge clock);
      t++;
    end
    chk("restore pc", {b[1], b[0]}, restore_pc);
    chk("restore x a", {b[2], b[3]}, {restore_x, restore_a});
    chk("restore cc", 16'(b[4]), 16'(restore_cc));
    @(negedge clock);
    chk("mask after return", 16'(b[4][3]), 16'(mask_bit));
    chk("hold released", 16'd0, 16'(cpu_hold));
  endtask
  task automatic no_entry;
    int seen;
    seen = 0;
    kick(DONE);
    repeat (12) begin
      @(negedge clock);
      if (push_valid !== 1'b0) seen++;
    end
    chk("unwanted entry", 16'd0, 16'(seen));
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    $display("[FAIL] watchdog expected finish seen timeout");
    num_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'haa561f37));
    cyc(10);
    rst_n <= 1'b1;
    wait_load;
    chk("reset vector", 16'hfffe, pc_value);
    chk("reset mask set", 16'd1, 16'(mask_set));
    cyc(2);
    @(negedge clock);
    chk("enable reset", 16'h0000, 16'(reg_rdata));
    setmask(1'b0);
    repeat (3) begin
      v = 8'($urandom);
      wreg(16'h0008, v);
      @(posedge clock);
      @(negedge clock);
      chk("enable rw", 16'(v), 16'(reg_rdata));
    end
    wreg(16'h0009, ~v);
    chk("unmapped read", 16'h0000, 16'(reg_rdata));
    @(posedge clock);
    reg_addr <= 16'h0008;
    @(posedge clock);
    @(negedge clock);
    chk("unmapped write", 16'(v), 16'(reg_rdata));
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      periph_enable <= 4'(1 << p);
      periph_flag <= 4'(1 << p);
      set_ctx;
      serve(vec_of_periph(p), DONE);
      clr(4'(1 << p));
    end
    setmask(1'b1);
    @(posedge clock);
    periph_enable <= 4'hf;
    periph_flag <= 4'h1;
    no_entry;
    setmask(1'b0);
    set_ctx;
    serve(16'hfff4, DONE);
    clr(4'h1);
    @(posedge clock);
    periph_enable <= 4'h0;
    periph_flag <= 4'h2;
    no_entry;
    clr(4'h2);
    @(posedge clock);
    periph_enable <= 4'h2;
    no_entry;
    @(posedge clock);
    periph_enable <= 4'hf;
    periph_flag <= 4'h5;
    kick(FLASH | SUSP);
    for (int i = 0; i < 4; i++) begin
      set_ctx;
      serve(order[i], DONE);
      if (i > 1) clr(i == 2 ? 4'h1 : 4'h4);
    end
    setmask(1'b1);
    kick(TRAP);
    set_ctx;
    serve(16'hfffc, DONE);
    setmask(1'b0);
    wreg(16'h0008, 8'hff);
    for (int i = 0; i < 8; i++) begin
      pin(i, 1'b1);
      cyc(8);
      set_ctx;
      serve(16'hfff6, DONE);
      pin(i, 1'b0);
      cyc(8);
    end
    no_entry;
    setmask(1'b1);
    pin(0, 1'b1);
    cyc(4);
    pin(0, 1'b0);
    no_entry;
    setmask(1'b0);
    set_ctx;
    serve(16'hfff6, DONE);
    set_ctx;
    kick(WAITC);
    cyc(3);
    @(posedge clock);
    periph_flag <= 4'h1;
    serve(16'hfff4, 7'h00);
    clr(4'h1);
    set_ctx;
    kick(HALTC);
    cyc(3);
    chk("osc off in halt", 16'd0, 16'(osc_enable));
    @(posedge clock);
    periph_flag <= 4'h1;
    no_entry;
    clr(4'h1);
    pin(2, 1'b1);
    serve(16'hfff6, 7'h00);
    chk("osc on after wake", 16'd1, 16'(osc_enable));
    pin(2, 1'b0);
    wreg(16'h0008, 8'h00);
    pin(3, 1'b1);
    cyc(8);
    no_entry;
    print_verdict;
  end
endmodule
`default_nettype wire
